// File: inc/drive_status_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef DRIVE_STATUS_REGS_SVH
`define DRIVE_STATUS_REGS_SVH
`define OFS_SELECT 8'h00
`define OFS_LEVEL 8'h04
`define OFS_BANDWIDTH 8'h08
`define OFS_MAXFREQ 8'h0C
`define OFS_OLWARN 8'h10
`define OFS_STATUS 8'h14
`define SEL_TERM_LSB 0
`define SEL_RELAY_LSB 8
`define SEL_MASK_LSB 16
`define OLW_TIME_LSB 8
`define STAT_OUT_LSB 24
`define RST_TERM_SEL 5'h0C
`define RST_RELAY_SEL 5'h11
`define RST_FAULT_MASK 3'h2
`define RST_LEVEL 13'h012C
`define RST_BANDWIDTH 13'h0064
`define RST_MAXFREQ 13'h0258
`define FREQ_LIMIT 13'h0FA0
`define RST_OLW_LEVEL 8'h96
`define RST_OLW_TIME 5'h0A
`define RST_COND 17'h00010
`define OLW_LEVEL_MIN 8'h1E
`define OLW_LEVEL_MAX 8'h96
`define OLW_TIME_MAX 5'h1E
`define FAULT_CODE 5'h11
`define PCLK_HZ 40000000
`define OLW_TICK_MS 100
`define OLW_TICKS_PER_S 4'hA
`endif

// File: inc/drive_status_pkg.sv
// shared types of the status output selector
package drive_status_pkg;
  typedef logic [12:0] freq_t;
  typedef logic [4:0] sel_t;
  typedef logic [2:0] mask_t;
  typedef logic [16:0] cond_t;
endpackage : drive_status_pkg

// File: inc/cond_if.sv
// condition vector and trip summary from evaluator to output selectors
`timescale 1ns/1ps
interface cond_if;
  drive_status_pkg::cond_t cond;
  logic trip_uv;
  logic trip_other;
  logic restart_cfg;
  modport src (output cond, output trip_uv, output trip_other, output restart_cfg);
  modport sel (input cond, input trip_uv, input trip_other, input restart_cfg);
endinterface : cond_if

// File: hw/status_out_sel.sv
// one output selector: chosen condition or masked fault, registered
`timescale 1ns/1ps
`include "drive_status_regs.svh"
module status_out_sel (
  input wire logic pclk,
  input wire logic presetn,
  cond_if.sel cif,
  input wire drive_status_pkg::sel_t code,
  input wire drive_status_pkg::mask_t mask,
  output logic out_r
);
  import drive_status_pkg::*;
  logic out_nxt;
  // fault code follows the mask, otherwise the chosen condition
  always_comb begin
    if (code == `FAULT_CODE) begin // [RULE_02]
      out_nxt = (mask[0] & cif.trip_uv) | (mask[1] & cif.trip_other) // [RULE_21]
        | (mask[2] & cif.restart_cfg & (cif.trip_uv | cif.trip_other));
    end else if (code < `FAULT_CODE) begin
      out_nxt = cif.cond[code]; // [RULE_01]
    end else begin
      out_nxt = 1'b0; // out-of-list codes are refused on write anyway
    end
  end
  // registered so the pin never glitches on a select change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_nxt; // [RULE_22]
    end
  end
endmodule : status_out_sel

// File: hw/drive_status_output_select.sv
// status output selector with frequency detection and apb registers
//
// Behaviour
// [RULE_01] two selectors, terminal and relay, codes 0-17
// [RULE_02] fault code drives output from fault mask
// [RULE_03] code 0: command/output frequency within half band
// [RULE_04] bandwidth 0-400 Hz, rejected above max
// [RULE_05] code 1: command equals level and match
// [RULE_06] level 0-400 Hz, rejected above max
// [RULE_07] code 2: running frequency near level
// [RULE_08] code 3: level reached, hysteresis half band
// [RULE_09] code 4: inverse of code 3
// [RULE_10] codes 5-7: overload warning, drive overload, stall
// [RULE_11] code 8: overvoltage trip
// [RULE_12] code 9: undervoltage trip
// [RULE_13] code 10: heatsink overheat
// [RULE_14] code 11: frequency command lost
// [RULE_15] code 12: run command and output active
// [RULE_16] code 13 stopped, code 14 constant speed
// [RULE_17] code 15: speed search in progress
// [RULE_18] code 16: waiting for run command
// [RULE_19] relay fault, mask 2: all but undervoltage
// [RULE_20] overload warning level 30-150 %, 0-30 s
// [RULE_21] mask bits: undervoltage, other trips, restart
// [RULE_22] outputs registered every cycle, glitch free
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "drive_status_regs.svh"
module drive_status_output_select #(
  parameter int TICK_CYCLES = `OLW_TICK_MS * (`PCLK_HZ / 1000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire drive_status_pkg::freq_t cmd_freq,
  input wire drive_status_pkg::freq_t run_freq,
  input wire logic [7:0] motor_current_pct,
  input wire logic drive_overload_cond,
  input wire logic stall_active,
  input wire logic ov_trip,
  input wire logic uv_trip,
  input wire logic other_trip,
  input wire logic heatsink_overheat_flag,
  input wire logic cmd_lost,
  input wire logic run_cmd,
  input wire logic output_active,
  input wire logic stopped,
  input wire logic constant_speed,
  input wire logic speed_search,
  input wire logic wait_run_cmd,
  input wire logic auto_restart_cfg,
  output logic status_terminal_out,
  output logic status_relay_out
);
  import drive_status_pkg::*;

  sel_t terminal_condition_select;
  sel_t relay_condition_select;
  mask_t fault_report_mask;
  freq_t freq_detect_level;
  freq_t freq_detect_bandwidth;
  freq_t max_frequency;
  logic [7:0] overload_warn_level;
  logic [4:0] overload_warn_time;
  cond_t cond_r;
  cond_t cond_nxt;
  logic hyst_r;
  logic motor_overload_warning;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic [8:0] warn_cnt_r;
  logic [31:0] rdata_nxt;
  logic wr_en;
  logic bad_wr;
  logic addr_ok;
  logic [12:0] wfreq;
  freq_t half_bw;
  freq_t cmd_run_diff;
  freq_t lvl_run_diff;
  freq_t hyst_low;
  logic freq_match_cond;
  logic [1:0] outs;
  cond_if cif ();

  // zero-wait slave: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign wfreq = pwdata[12:0];
  assign addr_ok = (paddr == `OFS_SELECT) || (paddr == `OFS_LEVEL)
    || (paddr == `OFS_BANDWIDTH) || (paddr == `OFS_MAXFREQ)
    || (paddr == `OFS_OLWARN) || (paddr == `OFS_STATUS);

  // out-of-range writes are refused whole and flagged by pslverr
  always_comb begin
    bad_wr = 1'b0;
    unique case (paddr)
      `OFS_SELECT: bad_wr = (pwdata[`SEL_TERM_LSB +: 5] > `FAULT_CODE)
        || (pwdata[`SEL_RELAY_LSB +: 5] > `FAULT_CODE);
      `OFS_LEVEL: bad_wr = (wfreq > max_frequency) || (pwdata[31:13] != 19'h0); // [RULE_06]
      `OFS_BANDWIDTH: bad_wr = (wfreq > max_frequency) || (pwdata[31:13] != 19'h0); // [RULE_04]
      `OFS_MAXFREQ: bad_wr = (wfreq > `FREQ_LIMIT) || (pwdata[31:13] != 19'h0);
      `OFS_OLWARN: bad_wr = (pwdata[7:0] < `OLW_LEVEL_MIN) // [RULE_20]
        || (pwdata[7:0] > `OLW_LEVEL_MAX)
        || (pwdata[`OLW_TIME_LSB +: 5] > `OLW_TIME_MAX);
      `OFS_STATUS: bad_wr = 1'b1;
      default: bad_wr = 1'b1;
    endcase
  end
  assign pslverr = psel & penable & (~addr_ok | (pwrite & bad_wr));

  // selectors and fault mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      terminal_condition_select <= `RST_TERM_SEL;
      relay_condition_select <= `RST_RELAY_SEL;
      fault_report_mask <= `RST_FAULT_MASK;
    end else if (wr_en && !bad_wr && paddr == `OFS_SELECT) begin
      terminal_condition_select <= pwdata[`SEL_TERM_LSB +: 5]; // [RULE_01]
      relay_condition_select <= pwdata[`SEL_RELAY_LSB +: 5];
      fault_report_mask <= pwdata[`SEL_MASK_LSB +: 3];
    end
  end

  // detection level, bandwidth and max frequency in 0.1 Hz units
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_detect_level <= `RST_LEVEL;
      freq_detect_bandwidth <= `RST_BANDWIDTH;
      max_frequency <= `RST_MAXFREQ;
    end else if (wr_en && !bad_wr) begin
      if (paddr == `OFS_LEVEL) begin
        freq_detect_level <= wfreq; // [RULE_06]
      end
      if (paddr == `OFS_BANDWIDTH) begin
        freq_detect_bandwidth <= wfreq; // [RULE_04]
      end
      if (paddr == `OFS_MAXFREQ) begin
        max_frequency <= wfreq;
      end
    end
  end

  // overload warning settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overload_warn_level <= `RST_OLW_LEVEL;
      overload_warn_time <= `RST_OLW_TIME;
    end else if (wr_en && !bad_wr && paddr == `OFS_OLWARN) begin
      overload_warn_level <= pwdata[7:0]; // [RULE_20]
      overload_warn_time <= pwdata[`OLW_TIME_LSB +: 5];
    end
  end

  // read data captured in the setup cycle so prdata comes from a flop
  always_comb begin
    rdata_nxt = 32'h0;
    unique case (paddr)
      `OFS_SELECT: rdata_nxt = {13'h0, fault_report_mask, 3'h0,
        relay_condition_select, 3'h0, terminal_condition_select};
      `OFS_LEVEL: rdata_nxt = {19'h0, freq_detect_level};
      `OFS_BANDWIDTH: rdata_nxt = {19'h0, freq_detect_bandwidth};
      `OFS_MAXFREQ: rdata_nxt = {19'h0, max_frequency};
      `OFS_OLWARN: rdata_nxt = {19'h0, overload_warn_time, overload_warn_level};
      `OFS_STATUS: rdata_nxt = {6'h0, outs, 7'h0, cond_r};
      default: rdata_nxt = 32'h0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= rdata_nxt;
    end
  end

  // 100 ms tick: warning time is counted in tenths of a second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h0;
    end else if (tick) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

  // warning once current stays above level for the set time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_cnt_r <= 9'h0;
    end else if (motor_current_pct <= overload_warn_level) begin
      warn_cnt_r <= 9'h0; // [RULE_20]
    end else if (tick && !motor_overload_warning) begin
      warn_cnt_r <= warn_cnt_r + 9'h1;
    end
  end
  assign motor_overload_warning = (motor_current_pct > overload_warn_level)
    && (warn_cnt_r >= 9'(overload_warn_time * `OLW_TICKS_PER_S));

  // frequency comparisons
  assign half_bw = freq_detect_bandwidth >> 1;
  assign cmd_run_diff = (cmd_freq > run_freq) ? cmd_freq - run_freq : run_freq - cmd_freq;
  assign lvl_run_diff = (freq_detect_level > run_freq) ? freq_detect_level - run_freq
    : run_freq - freq_detect_level;
  assign hyst_low = (freq_detect_level > half_bw) ? freq_detect_level - half_bw : 13'h0;
  assign freq_match_cond = (cmd_run_diff <= half_bw); // [RULE_03]

  // level-reached flag: set at the level, held until it drops to the bottom of the band
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyst_r <= 1'b0;
    end else if (run_freq >= freq_detect_level) begin
      hyst_r <= 1'b1; // [RULE_08]
    end else if (run_freq <= hyst_low || freq_detect_level == 13'h0) begin
      hyst_r <= 1'b0;
    end
  end

  // condition vector, one bit per selector code
  always_comb begin
    cond_nxt = '0;
    cond_nxt[0] = freq_match_cond; // [RULE_03]
    cond_nxt[1] = (cmd_freq == freq_detect_level) & freq_match_cond; // [RULE_05]
    cond_nxt[2] = (lvl_run_diff <= half_bw); // [RULE_07]
    cond_nxt[3] = hyst_r; // [RULE_08]
    cond_nxt[4] = ~hyst_r; // [RULE_09]
    cond_nxt[5] = motor_overload_warning; // [RULE_10]
    cond_nxt[6] = drive_overload_cond;
    cond_nxt[7] = stall_active;
    cond_nxt[8] = ov_trip; // [RULE_11]
    cond_nxt[9] = uv_trip; // [RULE_12]
    cond_nxt[10] = heatsink_overheat_flag; // [RULE_13]
    cond_nxt[11] = cmd_lost; // [RULE_14]
    cond_nxt[12] = run_cmd & output_active; // [RULE_15]
    cond_nxt[13] = stopped; // [RULE_16]
    cond_nxt[14] = constant_speed;
    cond_nxt[15] = speed_search; // [RULE_17]
    cond_nxt[16] = wait_run_cmd; // [RULE_18]
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_r <= `RST_COND; // level flag starts clear, so its inverse starts set
    end else begin
      cond_r <= cond_nxt; // [RULE_22]
    end
  end

  // trip summary for the fault code; other trips include overvoltage
  assign cif.cond = cond_r;
  assign cif.trip_uv = uv_trip;
  assign cif.trip_other = other_trip | ov_trip | heatsink_overheat_flag; // [RULE_19]
  assign cif.restart_cfg = auto_restart_cfg;

  // one selector per output: 0 terminal, 1 relay
  for (genvar g = 0; g < 2; g++) begin : g_out
    status_out_sel u_sel (
      .pclk(pclk),
      .presetn(presetn),
      .cif(cif),
      .code(g == 0 ? terminal_condition_select : relay_condition_select),
      .mask(fault_report_mask),
      .out_r(outs[g])
    );
  end
  assign status_terminal_out = outs[0];
  assign status_relay_out = outs[1];

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_term_follows;
    (terminal_condition_select < `FAULT_CODE) && $stable(terminal_condition_select)
      |-> status_terminal_out == $past(cond_r[terminal_condition_select]);
  endproperty
  a_term_follows: assert property (p_term_follows) else $error("terminal off selection"); // [RULE_01]
  property p_level_match;
    cond_r[1] |-> cond_r[0] && $past(cmd_freq == freq_detect_level);
  endproperty
  a_level_match: assert property (p_level_match) else $error("code 1 without code 0"); // [RULE_05]
  property p_inverted;
    (cond_r[4] != cond_r[3]) and (cond_r[4] |-> $past(run_freq < freq_detect_level, 2));
  endproperty
  a_inverted: assert property (p_inverted) else $error("code 4 not inverse"); // [RULE_09]
  property p_level_reject;
    wr_en && paddr == `OFS_LEVEL && wfreq > max_frequency |=> $stable(freq_detect_level);
  endproperty
  a_level_reject: assert property (p_level_reject) else $error("level above max taken"); // [RULE_06]
  property p_bw_reject;
    wr_en && paddr == `OFS_BANDWIDTH && wfreq > max_frequency
      |-> pslverr ##1 $stable(freq_detect_bandwidth);
  endproperty
  a_bw_reject: assert property (p_bw_reject) else $error("bandwidth above max taken"); // [RULE_04]
  property p_fault_uv;
    (relay_condition_select == `FAULT_CODE && fault_report_mask == 3'h2
      && uv_trip && !other_trip && !ov_trip && !heatsink_overheat_flag) [*2]
      |-> !status_relay_out;
  endproperty
  a_fault_uv: assert property (p_fault_uv) else $error("relay on undervoltage"); // [RULE_19]
  property p_fault_other;
    (relay_condition_select == `FAULT_CODE && fault_report_mask == 3'h2 && other_trip) [*2]
      |-> status_relay_out;
  endproperty
  a_fault_other: assert property (p_fault_other) else $error("relay off on trip"); // [RULE_19]
  property p_hyst_hold;
    hyst_r && run_freq > hyst_low |=> hyst_r && cond_r[3];
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("code 3 dropped early"); // [RULE_08]
  property p_running;
    cond_r[12] == $past(run_cmd & output_active);
  endproperty
  a_running: assert property (p_running) else $error("code 12 wrong"); // [RULE_15]
  property p_warn;
    motor_overload_warning |-> motor_current_pct > overload_warn_level;
  endproperty
  a_warn: assert property (p_warn) else $error("warning without overload"); // [RULE_20]
  property p_match;
    cond_r[0] |-> $past(cmd_run_diff <= half_bw);
  endproperty
  a_match: assert property (p_match) else $error("code 0 wrong"); // [RULE_03]

  c_fault_relay: cover property (relay_condition_select == `FAULT_CODE ##2 status_relay_out);
  c_hyst: cover property (cond_r[3] ##1 !cond_r[3]);
  c_reject: cover property (pslverr && pwrite);
endmodule : drive_status_output_select

// File: tb/status_reader.sv
// far-side model: external sequence scanning both status outputs
`timescale 1ns/1ps
module status_reader (
  input wire logic pclk,
  input wire logic term_in,
  input wire logic relay_in,
  output logic [1:0] seen_r
);
  // one scan per clock, so a glitch between edges is never latched
  always_ff @(posedge pclk) begin
    seen_r <= {relay_in, term_in};
  end
endmodule : status_reader

// File: tb/drive_status_output_select_tb.sv
// self-checking bench for the status output selector
`timescale 1ns/1ps
`include "drive_status_regs.svh"
module drive_status_output_select_tb;
  import drive_status_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, so_t, so_r, err;
  logic [7:0] paddr, cur;
  logic [31:0] pwdata, prdata, rd;
  freq_t cmd_f, run_f;
  logic [13:0] fl, f;
  logic [1:0] seen;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // short tick keeps the warning timer to tens of cycles
  drive_status_output_select #(.TICK_CYCLES(4)) u_drive_status_output_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_freq(cmd_f), .run_freq(run_f), .motor_current_pct(cur),
    .drive_overload_cond(fl[0]), .stall_active(fl[1]), .ov_trip(fl[2]), .uv_trip(fl[3]),
    .heatsink_overheat_flag(fl[4]), .cmd_lost(fl[5]), .run_cmd(fl[6]),
    .output_active(fl[7]), .stopped(fl[8]), .constant_speed(fl[9]), .speed_search(fl[10]),
    .wait_run_cmd(fl[11]), .auto_restart_cfg(fl[12]), .other_trip(fl[13]),
    .status_terminal_out(so_t), .status_relay_out(so_r));
  status_reader u_status_reader (.pclk(pclk), .term_in(so_t), .relay_in(so_r),
    .seen_r(seen));
  // 25 ns clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude;
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  task automatic bad(input string m);
    fail_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask : bad
  // one apb transfer; idle edge after release so psel is never driven twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    n_checks++;
    if (err !== e) bad("unexpected slave error flag");
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d, e);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h00000000, 1'b0);
    n_checks++;
    if (rd !== x) bad("register read mismatch");
  endtask : rdchk
  task automatic sel(input sel_t t, input sel_t r, input mask_t m);
    wr(`OFS_SELECT, {13'h0000, m, 3'h0, r, 3'h0, t}, 1'b0);
  endtask : sel
  // level flag, condition and output flops in the block, then the reader's scan
  task automatic drv(input freq_t c, input freq_t r, input logic [13:0] v,
    input logic [1:0] x);
    cmd_f <= c;
    run_f <= r;
    fl <= v;
    repeat (5) @(posedge pclk);
    n_checks++;
    if (seen !== x) bad("status outputs mismatch");
  endtask : drv
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    cmd_f = 13'h0000;
    run_f = 13'h0000;
    fl = 14'h0000;
    cur = 8'h00;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`OFS_SELECT, 32'h0002110C);
    rdchk(`OFS_LEVEL, 32'h0000012C);
    rdchk(`OFS_BANDWIDTH, 32'h00000064);
    rdchk(`OFS_MAXFREQ, 32'h00000258);
    rdchk(`OFS_OLWARN, 32'h00000A96);
    // refusals: unmapped, out of range, read-only
    apb(1'b0, 8'h18, 32'h00000000, 1'b1);
    wr(`OFS_SELECT, 32'h00000012, 1'b1);
    wr(`OFS_LEVEL, 32'h00000259, 1'b1);
    wr(`OFS_BANDWIDTH, 32'h00000259, 1'b1);
    wr(`OFS_OLWARN, 32'h0000001D, 1'b1);
    wr(`OFS_OLWARN, 32'h00001F64, 1'b1);
    wr(`OFS_STATUS, 32'h00000000, 1'b1);
    rdchk(`OFS_LEVEL, 32'h0000012C);
    rdchk(`OFS_OLWARN, 32'h00000A96);
    wr(`OFS_LEVEL, 32'h00000258, 1'b0);
    rdchk(`OFS_LEVEL, 32'h00000258);
    wr(`OFS_LEVEL, 32'h0000012C, 1'b0);
    drv(13'h0000, 13'h0000, 14'h0000, 2'b00);
    // level 30.0, half band 5.0; terminal code 0, relay code 2
    sel(5'h00, 5'h02, 3'h2);
    drv(13'h012C, 13'h015E, 14'h0000, 2'b11);
    drv(13'h012C, 13'h015F, 14'h0000, 2'b00);
    drv(13'h00C8, 13'h00F9, 14'h0000, 2'b01);
    sel(5'h01, 5'h02, 3'h2);
    drv(13'h012C, 13'h012C, 14'h0000, 2'b11);
    drv(13'h012D, 13'h012D, 14'h0000, 2'b10);
    drv(13'h012C, 13'h015F, 14'h0000, 2'b00);
    // hysteresis on terminal, inverted form on relay
    sel(5'h03, 5'h04, 3'h2);
    drv(13'h0000, 13'h00C8, 14'h0000, 2'b10);
    drv(13'h0000, 13'h012B, 14'h0000, 2'b10);
    drv(13'h0000, 13'h012C, 14'h0000, 2'b01);
    drv(13'h0000, 13'h00FB, 14'h0000, 2'b01);
    drv(13'h0000, 13'h00FA, 14'h0000, 2'b10);
    // each single-flag code set alone, then every other flag set instead
    for (int c = 6; c <= 16; c++) begin
      f = (c == 12) ? 14'h00C0 : 14'h0001 << ((c < 12) ? c - 6 : c - 5);
      sel(sel_t'(c), sel_t'(c), 3'h2);
      drv(13'h0000, 13'h0000, f, 2'b11);
      drv(13'h0000, 13'h0000, ~f, 2'b00);
    end
    sel(5'h0C, 5'h0C, 3'h2);
    drv(13'h0000, 13'h0000, 14'h0040, 2'b00);
    // overload warning: immediate at time 0, then 1 s = 40 cycles here
    wr(`OFS_OLWARN, 32'h00000064, 1'b0);
    sel(5'h05, 5'h05, 3'h2);
    cur <= 8'h64;
    drv(13'h0000, 13'h0000, 14'h0000, 2'b00);
    cur <= 8'h65;
    drv(13'h0000, 13'h0000, 14'h0000, 2'b11);
    cur <= 8'h00;
    drv(13'h0000, 13'h0000, 14'h0000, 2'b00);
    wr(`OFS_OLWARN, 32'h00000164, 1'b0);
    cur <= 8'h65;
    drv(13'h0000, 13'h0000, 14'h0000, 2'b00);
    repeat (50) @(posedge pclk);
    n_checks++;
    if (seen !== 2'b11) bad("warning not raised after hold time");
    cur <= 8'h00;
    // fault code with each mask bit
    sel(5'h11, 5'h11, 3'h2);
    drv(13'h0000, 13'h0000, 14'h0008, 2'b00);
    drv(13'h0000, 13'h0000, 14'h2000, 2'b11);
    // both frequencies zero: codes 0 and 4 hold as well
    rdchk(`OFS_STATUS, {6'h00, 2'b11, 7'h00, 17'h00011});
    drv(13'h0000, 13'h0000, 14'h0004, 2'b11);
    drv(13'h0000, 13'h0000, 14'h0010, 2'b11);
    sel(5'h11, 5'h11, 3'h1);
    drv(13'h0000, 13'h0000, 14'h0008, 2'b11);
    drv(13'h0000, 13'h0000, 14'h2000, 2'b00);
    sel(5'h11, 5'h11, 3'h4);
    drv(13'h0000, 13'h0000, 14'h1008, 2'b11);
    drv(13'h0000, 13'h0000, 14'h1000, 2'b00);
    sel(5'h11, 5'h11, 3'h0);
    drv(13'h0000, 13'h0000, 14'h301C, 2'b00);
    conclude();
  end
endmodule : drive_status_output_select_tb
